// [inc/modt_pkg.sv]
// Shared constants and types for the modulo overflow timer.
package modt_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_SC = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CLK = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CNTH = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CNTL = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_MODH = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_MODL = 5'h14;

  // Bit positions in timer_status_control.
  localparam int unsigned SC_OVF_BIT = 7;
  localparam int unsigned SC_OVIE_BIT = 6;
  localparam int unsigned SC_CRST_BIT = 5;
  localparam int unsigned SC_STOP_BIT = 4;

  // Field positions in the clock configuration register.
  localparam int unsigned CLK_SRC_LSB = 4;
  localparam int unsigned CLK_PS_LSB = 0;

  // Clock source select codes.
  localparam logic [1:0] SRC_BUS = 2'h0;
  localparam logic [1:0] SRC_FIXED = 2'h1;
  localparam logic [1:0] SRC_PIN_FALL = 2'h2;
  localparam logic [1:0] SRC_PIN_RISE = 2'h3;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [15:0] FREE_WRAP = 16'hFFFF;
  localparam logic [3:0] PS_RST = 4'h0;
  localparam logic [3:0] PS_MAX = 4'h8;
  localparam logic STOP_RST = 1'b1;

  // Index of each input in the synchroniser vector.
  localparam int unsigned SYNC_FIXED = 0;
  localparam int unsigned SYNC_PIN = 1;
  localparam int unsigned SYNC_W = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } modt_av_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic stop;
    logic ovie;
    logic ovf;
    logic arm;
    logic [1:0] src;
    logic [3:0] ps;
    logic [7:0] pre;
    logic [15:0] count;
    logic [15:0] modv;
    logic [15:0] mbuf;
    logic goth;
    logic gotl;
    logic pend;
    logic first_done;
    logic [15:0] cbuf;
    logic clat;
    logic cfirst_hi;
  } modt_st_t;

  localparam modt_st_t ST_RST = '{
    ack: 1'b0, rdata: 8'h00, stop: STOP_RST, ovie: 1'b0, ovf: 1'b0,
    arm: 1'b0, src: SRC_BUS, ps: PS_RST, pre: 8'h00, count: COUNT_RST,
    modv: MOD_RST, mbuf: MOD_RST, goth: 1'b0, gotl: 1'b0, pend: 1'b0,
    first_done: 1'b0, cbuf: COUNT_RST, clat: 1'b0, cfirst_hi: 1'b0
  };
endpackage

// [core/modt_edge_sync.sv]
// Two-stage synchroniser with edge detection for asynchronous inputs.
`timescale 1ns/100ps
module modt_edge_sync #(
  parameter int unsigned W = 2
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } modt_es_st_t;

  modt_es_st_t st_reg;
  modt_es_st_t st_next;

  // Only s2 and s3 feed the edge logic; s1 may be metastable.
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_edge
      assign rise_out[i] = st_reg.s2[i] & ~st_reg.s3[i];
      assign fall_out[i] = ~st_reg.s2[i] & st_reg.s3[i];
    end
  endgenerate
endmodule // modt_edge_sync

// [core/modt_timer.sv]
// Modulo overflow timer with prescaler and Avalon-MM register slave.
//
// Contract
// (R1) 16-bit up-counter, 16-bit modulo; stopped, free-running or modulo mode.
// (R2) Reset stops counter, zeroes count and modulo, bus clock, divide by one.
// (R3) Nonzero modulo counts modulo; zero modulo counts free-running.
// (R4) Counter runs only while the stop bit is clear.
// (R5) Sources: bus clock, fixed clock, pin rising or pin falling edge.
// (R6) Changing source while running keeps the count.
// (R7) Prescaler divides by 1 to 256 from the four-bit select.
// (R8) Changing prescale while running keeps the count.
// (R9) Any modulo from 0x0001 to 0xFFFF sets the overflow point.
// (R10) Count rises to the modulo, then wraps to zero next tick.
// (R11) Overflow flag sets on the transition from modulo to zero.
// (R12) Besides (R14), flag clears only by status read with flag set, then zero write.
// (R13) An overflow between that read and write keeps the flag set.
// (R14) Writing one to counter reset also clears the overflow flag.
// (R15) Interrupt request is high while flag and enable are both set.
// (R16) Software clears the flag before setting the interrupt enable.
// (R17) Reading one count byte latches both until the other is read.
// (R18) Modulo bytes apply together; first write after reset applies now.
// (R19) Two-bit source select resets to zero, the bus clock.
// (R20) Free-running wraps from 0xFFFF to zero and sets the flag.
// (R21) Pin edges are synchronised and edge-selected, one event each.
`timescale 1ns/100ps
module modt_timer (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire modt_pkg::modt_av_req_t avs_req_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic fixed_frequency_clock_in,
  input wire logic external_count_pin_in,
  output logic overflow_irq_out
);
  modt_pkg::modt_st_t st_reg;
  modt_pkg::modt_st_t st_next;

  logic [modt_pkg::SYNC_W-1:0] rise;
  logic [modt_pkg::SYNC_W-1:0] fall;
  logic take;
  logic rd_take;
  logic wr_take;
  logic src_ev;
  logic [7:0] pmask;
  logic tick;
  logic [15:0] wrap_pt;
  logic ovf_ev;
  logic [7:0] wbyte;
  logic [15:0] new_mod;

  modt_edge_sync #(
    .W(modt_pkg::SYNC_W)
  ) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .async_in({external_count_pin_in, fixed_frequency_clock_in}),
    .rise_out(rise),
    .fall_out(fall)
  );

  // One wait state: a request is taken on its first edge, answered next.
  assign take = (avs_req_in.read | avs_req_in.write) & ~st_reg.ack;
  assign rd_take = take & avs_req_in.read;
  assign wr_take = take & avs_req_in.write & avs_req_in.byteenable[0];
  assign avs_waitrequest_out = take;
  assign avs_readdata_out = {24'h000000, st_reg.rdata};
  assign wbyte = avs_req_in.writedata[7:0];
  assign overflow_irq_out = st_reg.ovf & st_reg.ovie; // see (R15)

  always_comb
  begin
    unique case (st_reg.src) // see (R5)
      modt_pkg::SRC_BUS: src_ev = 1'b1;
      modt_pkg::SRC_FIXED: src_ev = rise[modt_pkg::SYNC_FIXED];
      modt_pkg::SRC_PIN_FALL: src_ev = fall[modt_pkg::SYNC_PIN]; // see (R21)
      modt_pkg::SRC_PIN_RISE: src_ev = rise[modt_pkg::SYNC_PIN]; // see (R21)
    endcase
  end

  // Codes above eight divide by 256.
  always_comb
  begin
    pmask = 8'hFF;
    if (st_reg.ps < modt_pkg::PS_MAX)
    begin
      pmask = 8'((9'h001 << st_reg.ps) - 9'h001); // see (R7)
    end
  end

  assign tick = ~st_reg.stop & src_ev &
    ((st_reg.pre & pmask) == pmask); // see (R4)
  assign wrap_pt = (st_reg.modv == modt_pkg::MOD_RST) ?
    modt_pkg::FREE_WRAP : st_reg.modv; // see (R3)
  assign ovf_ev = tick & (st_reg.count == wrap_pt); // see (R10)

  always_comb
  begin
    new_mod = st_reg.mbuf;
    if (avs_req_in.address == modt_pkg::OFS_MODH)
    begin
      new_mod[15:8] = wbyte;
    end
    else
    begin
      new_mod[7:0] = wbyte;
    end
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.ack = take;

    // The prescaler keeps its phase across select changes.
    if (~st_reg.stop & src_ev)
    begin
      st_next.pre = st_reg.pre + 8'h01; // see (R6) (R8)
    end
    if (tick)
    begin
      if (ovf_ev)
      begin
        st_next.count = modt_pkg::COUNT_RST; // see (R10) (R20)
      end
      else
      begin
        st_next.count = st_reg.count + 16'h0001; // see (R1)
      end
    end
    // A buffered modulo lands on the next count tick, or at once if stopped.
    if (st_reg.pend & (tick | st_reg.stop))
    begin
      st_next.modv = st_reg.mbuf; // see (R18) (R9)
      st_next.pend = 1'b0;
    end

    if (rd_take)
    begin
      st_next.rdata = 8'h00;
      unique case (avs_req_in.address)
        modt_pkg::OFS_SC:
        begin
          st_next.rdata[modt_pkg::SC_OVF_BIT] = st_reg.ovf;
          st_next.rdata[modt_pkg::SC_OVIE_BIT] = st_reg.ovie;
          st_next.rdata[modt_pkg::SC_STOP_BIT] = st_reg.stop;
          if (st_reg.ovf)
          begin
            st_next.arm = 1'b1; // see (R12)
          end
        end
        modt_pkg::OFS_CLK:
        begin
          st_next.rdata[modt_pkg::CLK_SRC_LSB+:2] = st_reg.src;
          st_next.rdata[modt_pkg::CLK_PS_LSB+:4] = st_reg.ps;
        end
        modt_pkg::OFS_CNTH, modt_pkg::OFS_CNTL:
        begin
          if (~st_reg.clat)
          begin
            st_next.cbuf = st_reg.count; // see (R17)
            st_next.clat = 1'b1;
            st_next.cfirst_hi = (avs_req_in.address == modt_pkg::OFS_CNTH);
            st_next.rdata = (avs_req_in.address == modt_pkg::OFS_CNTH) ?
              st_reg.count[15:8] : st_reg.count[7:0];
          end
          else
          begin
            st_next.rdata = (avs_req_in.address == modt_pkg::OFS_CNTH) ?
              st_reg.cbuf[15:8] : st_reg.cbuf[7:0];
            if (st_reg.cfirst_hi != (avs_req_in.address ==
                modt_pkg::OFS_CNTH))
            begin
              st_next.clat = 1'b0; // see (R17)
            end
          end
        end
        modt_pkg::OFS_MODH:
        begin
          st_next.rdata = st_reg.modv[15:8];
        end
        modt_pkg::OFS_MODL:
        begin
          st_next.rdata = st_reg.modv[7:0];
        end
        default:
        begin
          st_next.rdata = 8'h00;
        end
      endcase
    end

    if (wr_take)
    begin
      unique case (avs_req_in.address)
        modt_pkg::OFS_SC:
        begin
          st_next.ovie = wbyte[modt_pkg::SC_OVIE_BIT];
          st_next.stop = wbyte[modt_pkg::SC_STOP_BIT]; // see (R4)
          st_next.arm = 1'b0;
          if (wbyte[modt_pkg::SC_CRST_BIT])
          begin
            st_next.count = modt_pkg::COUNT_RST;
            st_next.pre = 8'h00;
            st_next.ovf = 1'b0; // see (R14)
            st_next.clat = 1'b0; // see (R17)
            st_next.goth = 1'b0;
            st_next.gotl = 1'b0;
          end
          else if (~wbyte[modt_pkg::SC_OVF_BIT] & st_reg.arm)
          begin
            st_next.ovf = 1'b0; // see (R12)
          end
        end
        modt_pkg::OFS_CLK:
        begin
          st_next.src = wbyte[modt_pkg::CLK_SRC_LSB+:2]; // see (R19) (R6)
          st_next.ps = wbyte[modt_pkg::CLK_PS_LSB+:4]; // see (R8)
        end
        modt_pkg::OFS_MODH, modt_pkg::OFS_MODL:
        begin
          st_next.mbuf = new_mod;
          if (avs_req_in.address == modt_pkg::OFS_MODH)
          begin
            st_next.goth = 1'b1;
          end
          else
          begin
            st_next.gotl = 1'b1;
          end
          if (st_next.goth & st_next.gotl)
          begin
            st_next.goth = 1'b0;
            st_next.gotl = 1'b0;
            if (~st_reg.first_done)
            begin
              // The very first modulo after reset restarts the count.
              st_next.modv = new_mod; // see (R18)
              st_next.count = modt_pkg::COUNT_RST;
              st_next.pre = 8'h00;
              st_next.first_done = 1'b1;
              st_next.pend = 1'b0;
            end
            else
            begin
              st_next.pend = 1'b1; // see (R18)
            end
          end
        end
        default:
        begin
          st_next.arm = st_next.arm;
        end
      endcase
    end

    // An overflow wins over any clear in the same cycle and disarms it.
    if (ovf_ev)
    begin
      st_next.ovf = 1'b1; // see (R11) (R13)
      st_next.arm = 1'b0; // see (R13)
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      st_reg <= modt_pkg::ST_RST; // see (R2)
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  sequence s_req_taken;
    take;
  endsequence

  sequence s_answered;
    ~avs_waitrequest_out & st_reg.ack;
  endsequence

  property p_reset_state;
    @(posedge mclk_in) rst_in |=> st_reg.stop && st_reg.count == 16'h0000
      && st_reg.modv == 16'h0000 && st_reg.src == 2'h0 && st_reg.ps == 4'h0;
  endproperty
  a_reset_state: assert property (p_reset_state) // see (R2)
    else $error("reset state wrong");

  property p_stopped_holds;
    @(posedge mclk_in) disable iff (rst_in)
      st_reg.stop && !take |=> $stable(st_reg.count);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) // see (R4)
    else $error("count moved while stopped");

  property p_modulo_wrap;
    @(posedge mclk_in) disable iff (rst_in)
      tick && st_reg.modv != 16'h0000 && st_reg.count == st_reg.modv
      && !take |=> st_reg.count == 16'h0000 && st_reg.ovf;
  endproperty
  a_modulo_wrap: assert property (p_modulo_wrap) // see (R10)
    else $error("modulo wrap missed");

  property p_free_wrap;
    @(posedge mclk_in) disable iff (rst_in)
      tick && st_reg.modv == 16'h0000 && st_reg.count == 16'hFFFF
      && !take |=> st_reg.count == 16'h0000 && st_reg.ovf;
  endproperty
  a_free_wrap: assert property (p_free_wrap) // see (R20)
    else $error("free-running wrap missed");

  property p_count_step;
    @(posedge mclk_in) disable iff (rst_in)
      tick && st_reg.count != wrap_pt && !take
      |=> st_reg.count == $past(st_reg.count) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) // see (R1)
    else $error("count did not step by one");

  property p_div1;
    @(posedge mclk_in) disable iff (rst_in)
      !st_reg.stop && src_ev && st_reg.ps == 4'h0 |-> tick;
  endproperty
  a_div1: assert property (p_div1) // see (R7)
    else $error("divide by one lost a tick");

  property p_div256;
    @(posedge mclk_in) disable iff (rst_in)
      tick && st_reg.ps >= 4'h8 |-> st_reg.pre == 8'hFF;
  endproperty
  a_div256: assert property (p_div256) // see (R7)
    else $error("divide by 256 ticked early");

  property p_set_wins;
    @(posedge mclk_in) disable iff (rst_in)
      ovf_ev |=> st_reg.ovf;
  endproperty
  a_set_wins: assert property (p_set_wins) // see (R13)
    else $error("overflow lost against clear");

  property p_unarmed_keeps;
    @(posedge mclk_in) disable iff (rst_in)
      wr_take && avs_req_in.address == 5'h00 && !st_reg.arm
      && st_reg.ovf && !wbyte[5] |=> st_reg.ovf;
  endproperty
  a_unarmed_keeps: assert property (p_unarmed_keeps) // see (R12)
    else $error("flag cleared without read");

  property p_crst;
    @(posedge mclk_in) disable iff (rst_in)
      wr_take && avs_req_in.address == 5'h00 && wbyte[5] && !ovf_ev
      |=> !st_reg.ovf && st_reg.count == 16'h0000 && !st_reg.clat;
  endproperty
  a_crst: assert property (p_crst) // see (R14)
    else $error("counter reset did not clear");

  property p_irq;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(st_reg.ovf) && st_reg.ovie |-> overflow_irq_out;
  endproperty
  a_irq: assert property (p_irq) // see (R15)
    else $error("interrupt not raised");

  property p_answer;
    @(posedge mclk_in) disable iff (rst_in)
      s_req_taken |=> s_answered;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not one cycle after take");
endmodule // modt_timer

// [testbench/modulo_overflow_timer_tb.sv]
// Self-checking testbench for the modulo overflow timer.
`timescale 1ns/100ps
module modulo_overflow_timer_tb;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  modt_pkg::modt_av_req_t req = '0;
  logic [31:0] rdata;
  logic wait_req;
  logic fix_pin = 1'b0;
  logic ext_pin = 1'b0;
  logic irq;
  logic [7:0] cyc = 8'h00;
  logic [31:0] seed = 32'h0000005E;
  logic [15:0] last = 16'h0000;
  int fail_count = 0;
  int checks = 0;

  modt_timer i_modt_timer (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .avs_req_in(req),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req),
    .fixed_frequency_clock_in(fix_pin),
    .external_count_pin_in(ext_pin),
    .overflow_irq_out(irq)
  );

  always #50 mclk_in = ~mclk_in;

  // Both pins toggle every four clocks, so any 512-clock window holds
  // exactly 64 edges of each polarity whatever the phase.
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 8'h01;
    if (cyc[1:0] == 2'h3)
    begin
      fix_pin <= ~fix_pin;
      ext_pin <= ~ext_pin;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] exp_diff(input logic [1:0] s,
    input logic [3:0] p);
    int sh;
    int base;
    sh = (p > 4'h8) ? 8 : int'(p);
    base = (s == modt_pkg::SRC_BUS) ? 512 : 64;
    return 16'(base >> sh);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge mclk_in);
  endtask

  // The request is held until a rising edge sees waitrequest low.
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge mclk_in);
    req <= '{read: ~wr, write: wr, address: a, byteenable: 4'h1,
      writedata: {24'h000000, d}};
    n = 0;
    // Right after a rising edge the values seen are those sampled at it.
    @(posedge mclk_in);
    while (wait_req !== 1'b0)
    begin
      n++;
      if (n > 20)
      begin
        fail_count++;
        finish_test();
      end
      @(posedge mclk_in);
    end
    q = rdata[7:0];
    req <= '0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, e});
  endtask

  task automatic rdcnt(output logic [15:0] v);
    logic [7:0] l;
    logic [7:0] h;
    bus(1'b0, modt_pkg::OFS_CNTL, 8'h00, l);
    bus(1'b0, modt_pkg::OFS_CNTH, 8'h00, h);
    v = {h, l};
  endtask

  task automatic irq_is(input logic e);
    @(negedge mclk_in);
    chk({15'h0000, irq}, {15'h0000, e});
  endtask

  // Rate over an exact 512-clock window after a live reconfiguration.
  task automatic win(input logic [1:0] s, input logic [3:0] p);
    logic [15:0] v0;
    logic [15:0] v1;
    wr(modt_pkg::OFS_CLK, {2'h0, s, p});
    rdcnt(v0);
    chk({15'h0000, v0 >= last}, 16'h0001);
    gap(506);
    rdcnt(v1);
    chk(v1 - v0, exp_diff(s, p));
    last = v1;
  endtask

  task automatic setmod(input logic [15:0] v);
    wr(modt_pkg::OFS_MODH, v[15:8]);
    wr(modt_pkg::OFS_MODL, v[7:0]);
    rdchk(modt_pkg::OFS_MODH, v[15:8]);
    rdchk(modt_pkg::OFS_MODL, v[7:0]);
  endtask

  initial
  begin
    logic [15:0] v0;
    logic [15:0] v1;
    logic [3:0] pl [11];
    pl = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
      4'hF};
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
    rdchk(modt_pkg::OFS_SC, 8'h10);
    rdchk(modt_pkg::OFS_CLK, 8'h00);
    rdchk(modt_pkg::OFS_MODH, 8'h00);
    rdchk(modt_pkg::OFS_MODL, 8'h00);
    rdcnt(v0);
    chk(v0, 16'h0000);
    wr(5'h18, 8'hFF);
    rdchk(5'h18, 8'h00);
    irq_is(1'b0);
    $display("test reset done");

    wr(modt_pkg::OFS_SC, 8'h00);
    rdcnt(v0);
    rdcnt(v1);
    chk(v1 - v0, 16'h0006);
    wr(modt_pkg::OFS_SC, 8'h10);
    rdcnt(v0);
    gap(20);
    rdcnt(v1);
    chk(v1, v0);
    $display("test start stop done");

    wr(modt_pkg::OFS_SC, 8'h00);
    foreach (pl[i]) win(modt_pkg::SRC_BUS, pl[i]);
    win(modt_pkg::SRC_FIXED, 4'h0);
    win(modt_pkg::SRC_PIN_FALL, 4'h0);
    win(modt_pkg::SRC_PIN_RISE, 4'h0);
    win(modt_pkg::SRC_FIXED, 4'h1);
    $display("test sources done");

    wr(modt_pkg::OFS_CLK, 8'h00);
    wr(modt_pkg::OFS_SC, 8'h30);
    rdcnt(v0);
    chk(v0, 16'h0000);
    wr(modt_pkg::OFS_SC, 8'h00);
    wr(modt_pkg::OFS_MODH, 8'h00);
    wr(modt_pkg::OFS_MODL, 8'h0F);
    rdchk(modt_pkg::OFS_MODL, 8'h0F);
    repeat (4)
    begin
      gap(int'(rnd() % 32'd8));
      rdcnt(v0);
      chk({15'h0000, v0 <= 16'h000F}, 16'h0001);
    end
    gap(20);
    rdchk(modt_pkg::OFS_SC, 8'h80);
    rdchk(modt_pkg::OFS_SC, 8'h80);
    gap(16);
    wr(modt_pkg::OFS_SC, 8'h10);
    wr(modt_pkg::OFS_SC, 8'h10);
    rdchk(modt_pkg::OFS_SC, 8'h90);
    wr(modt_pkg::OFS_SC, 8'h10);
    rdchk(modt_pkg::OFS_SC, 8'h10);
    $display("test modulo flag done");

    // The enable is set only after the flag is clear.
    wr(modt_pkg::OFS_SC, 8'h50);
    irq_is(1'b0);
    wr(modt_pkg::OFS_SC, 8'h40);
    gap(20);
    irq_is(1'b1);
    wr(modt_pkg::OFS_SC, 8'h50);
    rdchk(modt_pkg::OFS_SC, 8'hD0);
    wr(modt_pkg::OFS_SC, 8'h70);
    irq_is(1'b0);
    rdcnt(v0);
    chk(v0, 16'h0000);
    wr(modt_pkg::OFS_SC, 8'h10);
    $display("test interrupt done");

    wr(modt_pkg::OFS_MODH, 8'h12);
    rdchk(modt_pkg::OFS_MODH, 8'h00);
    rdchk(modt_pkg::OFS_MODL, 8'h0F);
    wr(modt_pkg::OFS_MODL, 8'h34);
    rdchk(modt_pkg::OFS_MODH, 8'h12);
    rdchk(modt_pkg::OFS_MODL, 8'h34);
    repeat (3) setmod(16'(rnd() | 32'h1));
    setmod(16'hFFFF);
    setmod(16'h0001);
    setmod(16'h0000);
    $display("test modulo buffer done");

    wr(modt_pkg::OFS_SC, 8'h30);
    wr(modt_pkg::OFS_SC, 8'h00);
    gap(65400);
    rdchk(modt_pkg::OFS_SC, 8'h00);
    gap(200);
    rdchk(modt_pkg::OFS_SC, 8'h80);
    rdcnt(v0);
    chk({15'h0000, v0 < 16'h0100}, 16'h0001);
    $display("test free wrap done");
    finish_test();
  end
endmodule // modulo_overflow_timer_tb
